// File: tsts_checker.sv
// checker: bus handshake, trigger routing, sync delay and filter edges of tsts_top
// assumes it is bound to tsts_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module tsts_checker
  import tsts_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic              clk,                  // kernel clock
  input wire logic              reset,                // sync, active high
  input wire logic              psel,                 // apb select
  input wire logic              penable,              // apb access
  input wire logic              pwrite,               // apb direction
  input wire logic [ADDR_W-1:0] paddr,                // apb address
  input wire logic [31:0]       pwdata,               // apb write data
  input wire logic [3:0]        pstrb,                // apb strobes
  input wire logic              pready,               // apb ready
  input wire logic              pslverr,              // apb error
  input wire logic [3:0]        internal_trigger,     // internal lines
  input wire logic              channel1_in,          // raw channel 1
  input wire logic              channel1_filtered,    // filtered channel 1
  input wire logic              channel1_edge_detect, // channel 1 edge pulse
  input wire logic              trigger_input,        // selected trigger
  input wire logic              trigger_output,       // undelayed trigger
  input wire logic [2:0]        slave_mode_select     // slave mode
);
  logic [2:0] tsel_r;
  logic       mss_r;
  logic       src;
  logic       src_ok;
  logic       wr_ctrl;
  // shadow of the mss and tsel fields; tsel only moves while slave mode is off
  assign wr_ctrl = psel && penable && pwrite && pready && pstrb[0] && paddr == ADDR_W'(CTRL_OFFSET);
  always_ff @(posedge clk) begin
    if (reset) begin
      tsel_r <= TSEL_RESET;
      mss_r  <= MSS_RESET;
    end else if (wr_ctrl) begin
      mss_r  <= pwdata[MSS_BIT];
      tsel_r <= (slave_mode_select == MODE_RESET) ? pwdata[TSEL_LSB +: 3] : tsel_r;
    end
  end
  // codes 6 and 7 are left to the bench: their sources are not among these ports
  assign src    = tsel_r[2] ? (tsel_r[0] ? channel1_filtered : channel1_edge_detect) : internal_trigger[tsel_r[1:0]];
  assign src_ok = !(tsel_r[2] && tsel_r[1]);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  access_wait_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready without two access cycles");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  unmapped_err_a: assert property (pready && paddr != ADDR_W'(CTRL_OFFSET) && paddr != ADDR_W'(STATUS_OFFSET) |-> pslverr)
    else $error("unmapped access without error");
  source_route_a: assert property ($past(src_ok) && !$past(reset) |-> trigger_output == $past(src))
    else $error("trigger output not the selected source");
  sync_delay_a: assert property (mss_r && $past(mss_r, 2) && !$past(reset, 2) |-> trigger_input == $past(trigger_output))
    else $error("sync delay missing");
  no_delay_a: assert property (!mss_r && !$past(mss_r) |-> trigger_input == trigger_output)
    else $error("trigger delayed without sync bit");
  edge_pulse_a: assert property (channel1_edge_detect == $changed(channel1_filtered))
    else $error("edge pulse does not match filtered change");
  filter_level_a: assert property ($changed(channel1_filtered) |-> channel1_filtered == $past(channel1_in))
    else $error("filter moved against its input");
endmodule : tsts_checker
bind tsts_top tsts_checker #(.ADDR_W(ADDR_W)) i_tsts_checker (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .internal_trigger(internal_trigger),
  .channel1_in(channel1_in), .channel1_filtered(channel1_filtered), .channel1_edge_detect(channel1_edge_detect),
  .trigger_input(trigger_input), .trigger_output(trigger_output), .slave_mode_select(slave_mode_select)
);
`default_nettype wire

// File: tsts_peer.sv
// far side: other timers and pins feeding the raw trigger lines
// assumes the bench sets the wanted levels right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module tsts_peer (
  input  wire logic [6:0] want, // levels: lines 3..0, ch1, ch2, etr
  output logic      [3:0] itr,  // internal trigger lines
  output logic            ch1,  // channel 1 pin
  output logic            ch2,  // channel 2 pin
  output logic            etr   // external trigger pin
);
  assign {itr, ch1, ch2, etr} = want;
endmodule : tsts_peer
`default_nettype wire

// File: tsts_pkg.sv
// constants and types for the timer slave trigger select block
// assumes a single 20 MHz kernel clock that also serves as the dead-time clock
package tsts_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned DTS_HZ          = CLK_HZ;

  // register byte offsets
  localparam logic [11:0] CTRL_OFFSET     = 12'h000;
  localparam logic [11:0] STATUS_OFFSET   = 12'h004;

  // control field positions
  localparam int unsigned MODE_LSB        = 0;
  localparam int unsigned TSEL_LSB        = 4;
  localparam int unsigned MSS_BIT         = 7;
  localparam int unsigned FILT_LSB        = 8;

  localparam logic [2:0]  MODE_RESET      = 3'h0;
  localparam logic [2:0]  TSEL_RESET      = 3'h0;
  localparam logic        MSS_RESET       = 1'b0;
  localparam logic [3:0]  FILT_RESET      = 4'h0;

  // trigger selector codes
  localparam logic [2:0]  TSEL_INT0       = 3'h0;
  localparam logic [2:0]  TSEL_INT1       = 3'h1;
  localparam logic [2:0]  TSEL_INT2       = 3'h2;
  localparam logic [2:0]  TSEL_INT3       = 3'h3;
  localparam logic [2:0]  TSEL_CH1_EDGE   = 3'h4;
  localparam logic [2:0]  TSEL_CH1_FILT   = 3'h5;
  localparam logic [2:0]  TSEL_CH2_FILT   = 3'h6;
  localparam logic [2:0]  TSEL_ETR_FILT   = 3'h7;

  // filter codes with a documented rate and sample count
  localparam logic [3:0]  FILT_D16_N6     = 4'hb;
  localparam logic [3:0]  FILT_D16_N8     = 4'hc;
  localparam logic [3:0]  FILT_D32_N5     = 4'hd;
  localparam logic [3:0]  FILT_D32_N6     = 4'he;
  localparam logic [3:0]  FILT_D32_N8     = 4'hf;

  localparam int unsigned DIV16           = 16;
  localparam int unsigned DIV32           = 32;
  localparam logic [4:0]  DIV16_LAST      = 5'(DIV16 - 1);
  localparam logic [4:0]  DIV32_LAST      = 5'(DIV32 - 1);

  // extra kernel cycles that the sync bit holds back the local trigger
  localparam int unsigned MSS_DELAY_CYC   = 1;

  localparam int unsigned NUM_FILT        = 3;
  localparam int unsigned FI_CH1          = 0;
  localparam int unsigned FI_CH2          = 1;
  localparam int unsigned FI_ETR          = 2;

  typedef enum logic [1:0] {
    RATE_FULL,
    RATE_D16,
    RATE_D32
  } tsts_rate_t;

  typedef struct packed {
    tsts_rate_t  rate;
    logic [3:0]  n;
  } tsts_fcfg_t;

  typedef struct packed {
    logic [3:0]  filt;
    logic        mss;
    logic [2:0]  tsel;
    logic [2:0]  mode;
  } tsts_ctrl_t;

  localparam tsts_ctrl_t CTRL_RESET = '{filt: FILT_RESET, mss: MSS_RESET, tsel: TSEL_RESET, mode: MODE_RESET};

endpackage : tsts_pkg

// File: tsts_tb_top.sv
// testbench for tsts_top: register access, source routing, sync delay, selector lock, filters
// assumes a 20 MHz clock and the peer model driving the raw trigger lines
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tsts_tb_top;
  import tsts_pkg::*;
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [6:0]  want = 0;
  logic [3:0]  itr;
  logic [3:0]  pstrb = 4'hf;
  logic        ch1, ch2, etr, chf1, chf2, pready, pslverr, ti, to;
  int          errors = 0, cmp_count = 0, n;
  logic [3:0]  fc [2] = '{FILT_D32_N6, FILT_D32_N8};
  int          fn [2] = '{6, 8};
  always #25 clk = ~clk;
  tsts_peer i_tsts_peer (.want(want), .itr(itr), .ch1(ch1), .ch2(ch2), .etr(etr));
  tsts_top i_tsts_top (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_trigger(itr), .channel1_in(ch1), .channel2_in(ch2), .external_trigger_in(etr),
    .channel1_filtered(chf1), .channel2_filtered(chf2), .external_trigger_filtered(),
    .channel1_edge_detect(), .trigger_input(ti), .trigger_output(to), .slave_mode_select());
  function automatic logic [31:0] cv(logic [3:0] f, logic m, logic [2:0] t, logic [2:0] s);
    return {20'h0_0000, f, m, t, 1'b0, s};
  endfunction : cv
  // one apb transfer; read data is compared only on reads
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x, input logic ee);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) errors++;
    `CHK(pslverr, ee)
    if (!w) `CHK(prdata, x)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : acc
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  initial begin
    #(20_000 * 50);
    errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    acc(0, CTRL_OFFSET, 0, cv(FILT_RESET, MSS_RESET, TSEL_RESET, MODE_RESET), 0);
    acc(0, STATUS_OFFSET, 0, 32'h0000_0000, 0);
    acc(0, 12'h008, 0, 32'h0000_0000, 1);
    acc(1, STATUS_OFFSET, 32'h0000_000f, 0, 1);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      acc(1, CTRL_OFFSET, cv(4'h0, 1'b0, 3'(i), 3'h0), 0, 0);
      // one source at a time so a swapped route cannot pass
      want <= (i < 4) ? 7'(1 << (i + 3)) : (i == 4) ? 7'h04 : 7'(1 << (7 - i));
      n = 0;
      repeat (12) begin
        @(posedge clk);
        n += int'(ti === 1'b1);
      end
      `CHK((i == 4) ? (n == 1) : (n >= 9), 1'b1)
      want <= 7'h00;
      repeat (4) @(posedge clk);
    end
    $display("test routing done");
    for (int m = 1; m >= 0; m--) begin
      acc(1, CTRL_OFFSET, cv(4'h0, 1'(m), 3'h1, 3'h0), 0, 0);
      want <= 7'h10;
      n = 0;
      while (to !== 1'b1 && n < 10) begin
        @(posedge clk);
        n++;
      end
      `CHK(ti, ~1'(m))
      @(posedge clk);
      `CHK(ti, 1'b1)
      want <= 7'h00;
      repeat (4) @(posedge clk);
    end
    $display("test sync done");
    // second write arrives while slave mode is on, so its selector must be dropped
    acc(1, CTRL_OFFSET, cv(4'h0, 1'b0, 3'h2, 3'h1), 0, 0);
    acc(1, CTRL_OFFSET, cv(4'h0, 1'b0, 3'h3, 3'h1), 0, 0);
    acc(0, CTRL_OFFSET, 0, cv(4'h0, 1'b0, 3'h2, 3'h1), 0);
    acc(1, CTRL_OFFSET, cv(4'h0, 1'b0, 3'h3, 3'h0), 0, 0);
    acc(1, CTRL_OFFSET, cv(4'h0, 1'b0, 3'h3, 3'h0), 0, 0);
    acc(0, CTRL_OFFSET, 0, cv(4'h0, 1'b0, 3'h3, 3'h0), 0);
    $display("test lock done");
    for (int k = 0; k < 2; k++) begin
      acc(1, CTRL_OFFSET, cv(fc[k], 1'b0, 3'h0, 3'h0), 0, 0);
      want <= 7'h07;
      repeat (100) @(posedge clk);
      want <= 7'h03;
      @(posedge clk);
      want <= 7'h07;
      n = 0;
      while (chf1 !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      `CHK(n > (fn[k] - 1) * 32 && n <= fn[k] * 32 + 1, 1'b1)
      `CHK(chf2, 1'b1)
      want <= 7'h00;
      repeat (300) @(posedge clk);
    end
    $display("test filters done");
    results();
  end
endmodule : tsts_tb_top
`default_nettype wire

// File: tsts_top.sv
// timer slave trigger select: input filters, trigger source mux, sync delay, apb registers
// assumes all inputs synchronous to clk; slave mode engine sits outside and reads slave_mode_select
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tsts_top
  import tsts_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              clk,                    // kernel clock, 20 MHz
  input  wire logic              reset,                  // synchronous, active high
  input  wire logic              psel,                   // apb select
  input  wire logic              penable,                // apb access phase
  input  wire logic              pwrite,                 // apb direction
  input  wire logic [ADDR_W-1:0] paddr,                  // apb byte address
  input  wire logic [31:0]       pwdata,                 // apb write data
  input  wire logic [3:0]        pstrb,                  // apb byte strobes
  output logic      [31:0]       prdata,                 // apb read data
  output logic                   pready,                 // apb ready
  output logic                   pslverr,                // apb error, unmapped address or status write
  input  wire logic [3:0]        internal_trigger,       // internal trigger lines 0..3
  input  wire logic              channel1_in,            // raw channel 1 input
  input  wire logic              channel2_in,            // raw channel 2 input
  input  wire logic              external_trigger_in,    // raw external trigger input
  output logic                   channel1_filtered,      // filtered channel 1
  output logic                   channel2_filtered,      // filtered channel 2
  output logic                   external_trigger_filtered, // filtered external trigger
  output logic                   channel1_edge_detect,   // pulse on any filtered ch1 edge
  output logic                   trigger_input,          // selected trigger for this counter
  output logic                   trigger_output,         // undelayed trigger toward slave timers
  output logic      [2:0]        slave_mode_select       // slave mode to the mode engine
);

  if (ADDR_W < 3 || ADDR_W > 12) begin : g_bad_addr_w
    $error("tsts_top: ADDR_W must lie in 3..12");
  end

  function automatic tsts_fcfg_t filt_cfg(input logic [3:0] code);
    tsts_fcfg_t c;
    c = '{rate: RATE_FULL, n: 4'h1};
    case (code)
      FILT_D16_N6: c = '{rate: RATE_D16, n: 4'h6};
      FILT_D16_N8: c = '{rate: RATE_D16, n: 4'h8};
      FILT_D32_N5: c = '{rate: RATE_D32, n: 4'h5};
      FILT_D32_N6: c = '{rate: RATE_D32, n: 4'h6};
      FILT_D32_N8: c = '{rate: RATE_D32, n: 4'h8};
      default:     c = '{rate: RATE_FULL, n: 4'h1};
    endcase
    return c;
  endfunction : filt_cfg

  // registers
  tsts_ctrl_t            ctrl_r,    ctrl_nxt;
  logic [31:0]           prdata_r,  prdata_nxt;
  logic                  pready_r,  pready_nxt;
  logic                  pslverr_r, pslverr_nxt;
  logic [4:0]            div_r,     div_nxt;
  logic [NUM_FILT-1:0]   fout_r,    fout_nxt;
  logic [3:0]            fcnt_r [NUM_FILT];
  logic [3:0]            fcnt_nxt [NUM_FILT];
  logic                  edge_r,    edge_nxt;
  logic                  tout_r,    tout_nxt;
  logic                  tin_r,     tin_nxt;
  logic [MSS_DELAY_CYC-1:0] dly_r,  dly_nxt;

  tsts_fcfg_t            fcfg;
  logic                  samp_en;
  logic [NUM_FILT-1:0]   fin;
  logic                  sel_trig;
  logic                  hit_ctrl;
  logic                  hit_stat;
  logic                  wr_done;
  logic [31:0]           wmask;

  assign fin[FI_CH1] = channel1_in;
  assign fin[FI_CH2] = channel2_in;
  assign fin[FI_ETR] = external_trigger_in;

  // sampling divider and filters
  always_comb begin
    fcfg    = filt_cfg(ctrl_r.filt);
    div_nxt = div_r + 5'h01;
    case (fcfg.rate)
      RATE_D16: samp_en = (div_r[3:0] == DIV16_LAST[3:0]);
      RATE_D32: samp_en = (div_r == DIV32_LAST);
      default:  samp_en = 1'b1;
    endcase
    fout_nxt = fout_r;
    for (int i = 0; i < NUM_FILT; i++) begin
      fcnt_nxt[i] = fcnt_r[i];
      if (fin[i] == fout_r[i]) begin
        fcnt_nxt[i] = 4'h0;                            // an input equal to the output restarts the run
      end else if (samp_en) begin
        if (fcnt_r[i] + 4'h1 >= fcfg.n) begin
          fout_nxt[i] = fin[i];
          fcnt_nxt[i] = 4'h0;
        end else begin
          fcnt_nxt[i] = fcnt_r[i] + 4'h1;
        end
      end
    end
    edge_nxt = fout_nxt[FI_CH1] ^ fout_r[FI_CH1];
  end

  // trigger selection and sync delay
  always_comb begin
    case (ctrl_r.tsel)
      TSEL_INT0:     sel_trig = internal_trigger[0];
      TSEL_INT1:     sel_trig = internal_trigger[1];
      TSEL_INT2:     sel_trig = internal_trigger[2];
      TSEL_INT3:     sel_trig = internal_trigger[3];
      TSEL_CH1_EDGE: sel_trig = edge_r;
      TSEL_CH1_FILT: sel_trig = fout_r[FI_CH1];
      TSEL_CH2_FILT: sel_trig = fout_r[FI_CH2];
      TSEL_ETR_FILT: sel_trig = fout_r[FI_ETR];
      default:       sel_trig = 1'b0;
    endcase
    tout_nxt = sel_trig;
    // slaves see trigger_output now; the local counter waits so both start together
    dly_nxt  = MSS_DELAY_CYC'({dly_r, sel_trig});
    tin_nxt  = ctrl_r.mss ? dly_r[MSS_DELAY_CYC-1] : sel_trig;
  end

  // apb slave: one wait state, answer two cycles after the setup edge
  always_comb begin
    hit_ctrl    = (paddr == CTRL_OFFSET[ADDR_W-1:0]);
    hit_stat    = (paddr == STATUS_OFFSET[ADDR_W-1:0]);
    wr_done     = psel && penable && pready_r && pwrite && hit_ctrl;
    pready_nxt  = psel && penable && !pready_r;
    pslverr_nxt = pready_nxt && !(hit_ctrl || (hit_stat && !pwrite));
    prdata_nxt  = 32'h0000_0000;
    if (pready_nxt && !pwrite && hit_ctrl) begin
      prdata_nxt = {20'h0_0000, ctrl_r.filt, ctrl_r.mss, ctrl_r.tsel, 1'b0, ctrl_r.mode};
    end else if (pready_nxt && !pwrite && hit_stat) begin
      prdata_nxt = {28'h000_0000, tin_r, fout_r[FI_ETR], fout_r[FI_CH2], fout_r[FI_CH1]};
    end
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    ctrl_nxt = ctrl_r;
    if (wr_done) begin
      if (wmask[MODE_LSB]) begin
        ctrl_nxt.mode = pwdata[MODE_LSB +: 3];
      end
      // selector held while slave mode runs, a live switch could fake an edge
      if (wmask[TSEL_LSB] && ctrl_r.mode == MODE_RESET) begin
        ctrl_nxt.tsel = pwdata[TSEL_LSB +: 3];
      end
      if (wmask[MSS_BIT]) begin
        ctrl_nxt.mss = pwdata[MSS_BIT];
      end
      if (wmask[FILT_LSB]) begin
        ctrl_nxt.filt = pwdata[FILT_LSB +: 4];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r    <= CTRL_RESET;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      div_r     <= 5'h00;
      fout_r    <= '0;
      edge_r    <= 1'b0;
      tout_r    <= 1'b0;
      tin_r     <= 1'b0;
      dly_r     <= '0;
      for (int i = 0; i < NUM_FILT; i++) begin
        fcnt_r[i] <= 4'h0;
      end
    end else begin
      ctrl_r    <= ctrl_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      div_r     <= div_nxt;
      fout_r    <= fout_nxt;
      edge_r    <= edge_nxt;
      tout_r    <= tout_nxt;
      tin_r     <= tin_nxt;
      dly_r     <= dly_nxt;
      for (int i = 0; i < NUM_FILT; i++) begin
        fcnt_r[i] <= fcnt_nxt[i];
      end
    end
  end

  assign prdata                    = prdata_r;
  assign pready                    = pready_r;
  assign pslverr                   = pslverr_r;
  assign channel1_filtered         = fout_r[FI_CH1];
  assign channel2_filtered         = fout_r[FI_CH2];
  assign external_trigger_filtered = fout_r[FI_ETR];
  assign channel1_edge_detect      = edge_r;
  assign trigger_input             = tin_r;
  assign trigger_output            = tout_r;
  assign slave_mode_select         = ctrl_r.mode;

endmodule : tsts_top
`default_nettype wire
